/* File: core/modbus_pkg.sv */
// Operation
// - request carries station id, function, start register, count; act only on own id or wildcard id 0
// - read of one register answers id, 03, byte count 02, data msb first, crc
// - register zero returns the radiation reading in W/m2 unscaled
// - write to 0x0100 replaces station id; later frames match the new id
// - successful write is answered by echoing the request byte for byte
// - write to 0x0101 sets line-rate code; code 2 selects 19200 baud
// - every frame ends in crc16 over preceding bytes; check before acting
// - line-rate codes 0..5 decode to 4800,9600,19200,38400,57600,115200 baud
// - station ids 1..254 valid; id 0 accepted as wildcard
// - coefficient is high*256 plus low, in units of 0.01
package modbus_pkg;

  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE = 8'h06;
  localparam logic [7:0] BYTE_COUNT_ONE = 8'h02;
  localparam logic [15:0] READ_COUNT_ONE = 16'h0001;

  localparam logic [15:0] REG_READING = 16'h0000;
  localparam logic [15:0] REG_STATION = 16'h0100;
  localparam logic [15:0] REG_RATE = 16'h0101;
  localparam logic [15:0] REG_COEF_HI = 16'h0108;
  localparam logic [15:0] REG_COEF_LO = 16'h0109;

  localparam logic [7:0] ID_WILDCARD = 8'h00;
  localparam logic [7:0] ID_MIN = 8'h01;
  localparam logic [7:0] ID_MAX = 8'hfe;
  localparam logic [2:0] RATE_CODE_MAX = 3'h5;

  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [2:0] RATE_RST = 3'h1;
  localparam logic [15:0] COEF_HI_RST = 16'h0000;
  localparam logic [15:0] COEF_LO_RST = 16'h0064;

  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  localparam logic [2:0] POS_ID = 3'h0;
  localparam logic [2:0] POS_FUNC = 3'h1;
  localparam logic [2:0] POS_ADDR_HI = 3'h2;
  localparam logic [2:0] POS_ADDR_LO = 3'h3;
  localparam logic [2:0] POS_VAL_HI = 3'h4;
  localparam logic [2:0] POS_VAL_LO = 3'h5;
  localparam logic [2:0] POS_CRC_HI = 3'h6;
  localparam logic [2:0] POS_LAST = 3'h7;
  localparam logic [2:0] FRAME_ADDR_W = 3'h3;

  localparam logic [16:0] BAUD_4800 = 17'd4800;
  localparam logic [16:0] BAUD_9600 = 17'd9600;
  localparam logic [16:0] BAUD_19200 = 17'd19200;
  localparam logic [16:0] BAUD_38400 = 17'd38400;
  localparam logic [16:0] BAUD_57600 = 17'd57600;
  localparam logic [16:0] BAUD_115200 = 17'd115200;

  typedef enum logic [2:0]
  {
    ST_RECV = 3'b000,
    ST_EXEC = 3'b001,
    ST_FETCH = 3'b010,
    ST_LOAD = 3'b011,
    ST_SEND = 3'b100,
    ST_DROP = 3'b101
  } state_t;

  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_step

  function automatic logic [16:0] baud_of(input logic [2:0] code);
    logic [16:0] b;
    case (code)
      3'h0: b = BAUD_4800;
      3'h1: b = BAUD_9600;
      3'h2: b = BAUD_19200;
      3'h3: b = BAUD_38400;
      3'h4: b = BAUD_57600;
      default: b = BAUD_115200;
    endcase
    return b;
  endfunction : baud_of

endpackage : modbus_pkg

/* File: core/frame_buffer.sv */
module frame_buffer
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic [2:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [2:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  import modbus_pkg::*;

  logic [7:0] mem [0:7];
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  always_ff @(posedge i_core_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_comb
  begin
    rd_data_nxt = mem[i_rd_addr];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_data_r <= 8'h00;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign o_rd_data = rd_data_r;

endmodule : frame_buffer

/* File: core/radiation_sensor_modbus_slave.sv */
module radiation_sensor_modbus_slave
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_gap,
  input wire logic i_tx_ready,
  input wire logic [15:0] i_reading,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic [7:0] o_station_id,
  output logic [2:0] o_line_rate_code,
  output logic [16:0] o_baud_rate,
  output logic [23:0] o_coefficient
);
  import modbus_pkg::*;

  modbus_pkg::state_t state_r, state_nxt;
  logic [2:0] rx_cnt_r, rx_cnt_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic [7:0] rx_id_r, rx_id_nxt;
  logic [7:0] rx_func_r, rx_func_nxt;
  logic [15:0] rx_addr_r, rx_addr_nxt;
  logic [15:0] rx_val_r, rx_val_nxt;
  logic echo_r, echo_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [15:0] rd_word_r, rd_word_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic [7:0] station_r, station_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic [15:0] coef_hi_r, coef_hi_nxt;
  logic [15:0] coef_lo_r, coef_lo_nxt;
  logic [16:0] baud_r, baud_nxt;
  logic [23:0] coef_r, coef_nxt;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic id_ok;
  logic rd_mapped;
  logic wr_ok;
  logic [15:0] rd_sel;
  logic [7:0] out_byte;
  logic [2:0] last_idx;

  frame_buffer u_frame_buffer
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_wr_en(mem_we),
    .i_wr_addr(rx_cnt_r),
    .i_wr_data(i_rx_data),
    .i_rd_addr(idx_r),
    .o_rd_data(mem_rdata)
  );

  // request bytes kept for echo
  assign mem_we = (state_r == ST_RECV) && i_rx_valid;

  always_comb
  begin
    state_nxt = state_r;
    rx_cnt_nxt = rx_cnt_r;
    crc_nxt = crc_r;
    rx_id_nxt = rx_id_r;
    rx_func_nxt = rx_func_r;
    rx_addr_nxt = rx_addr_r;
    rx_val_nxt = rx_val_r;
    echo_nxt = echo_r;
    idx_nxt = idx_r;
    rd_word_nxt = rd_word_r;
    tx_valid_nxt = tx_valid_r;
    tx_data_nxt = tx_data_r;
    station_nxt = station_r;
    rate_nxt = rate_r;
    coef_hi_nxt = coef_hi_r;
    coef_lo_nxt = coef_lo_r;
    id_ok = (rx_id_r == station_r) || (rx_id_r == ID_WILDCARD);
    rd_mapped = 1'b1;
    wr_ok = 1'b0;
    rd_sel = 16'h0000;
    out_byte = 8'h00;
    last_idx = echo_r ? POS_LAST : POS_CRC_HI;
    case (rx_addr_r)
      REG_READING: rd_sel = i_reading;
      REG_STATION: rd_sel = {8'h00, station_r};
      REG_RATE: rd_sel = {13'h0000, rate_r};
      REG_COEF_HI: rd_sel = coef_hi_r;
      REG_COEF_LO: rd_sel = coef_lo_r;
      default: rd_mapped = 1'b0;
    endcase
    case (idx_r)
      POS_ID: out_byte = station_r;
      POS_FUNC: out_byte = FUNC_READ;
      POS_ADDR_HI: out_byte = BYTE_COUNT_ONE;
      POS_ADDR_LO: out_byte = rd_word_r[15:8];
      POS_VAL_HI: out_byte = rd_word_r[7:0];
      POS_VAL_LO: out_byte = crc_r[7:0];
      default: out_byte = crc_r[15:8];
    endcase
    case (state_r)
      ST_RECV:
      begin
        if (i_rx_gap)
        begin
          rx_cnt_nxt = POS_ID;
          crc_nxt = CRC_INIT;
        end
        else if (i_rx_valid)
        begin
          crc_nxt = crc16_step(crc_r, i_rx_data);
          rx_cnt_nxt = rx_cnt_r + 3'h1;
          case (rx_cnt_r)
            POS_ID: rx_id_nxt = i_rx_data;
            POS_FUNC: rx_func_nxt = i_rx_data;
            POS_ADDR_HI: rx_addr_nxt = {i_rx_data, rx_addr_r[7:0]};
            POS_ADDR_LO: rx_addr_nxt = {rx_addr_r[15:8], i_rx_data};
            POS_VAL_HI: rx_val_nxt = {i_rx_data, rx_val_r[7:0]};
            POS_VAL_LO: rx_val_nxt = {rx_val_r[15:8], i_rx_data};
            default: rx_val_nxt = rx_val_r;
          endcase
          if (rx_cnt_r == POS_LAST)
          begin
            state_nxt = ST_EXEC;
          end
        end
      end
      ST_EXEC:
      begin
        idx_nxt = POS_ID;
        state_nxt = ST_DROP;
        if ((crc_r == CRC_GOOD) && id_ok)
        begin
          if ((rx_func_r == FUNC_READ) && (rx_val_r == READ_COUNT_ONE) && rd_mapped)
          begin
            rd_word_nxt = rd_sel;
            echo_nxt = 1'b0;
            crc_nxt = CRC_INIT;
            state_nxt = ST_FETCH;
          end
          else if (rx_func_r == FUNC_WRITE)
          begin
            case (rx_addr_r)
              REG_STATION:
              begin
                if ((rx_val_r >= {8'h00, ID_MIN}) && (rx_val_r <= {8'h00, ID_MAX}))
                begin
                  station_nxt = rx_val_r[7:0];
                  wr_ok = 1'b1;
                end
              end
              REG_RATE:
              begin
                if (rx_val_r <= {13'h0000, RATE_CODE_MAX})
                begin
                  rate_nxt = rx_val_r[2:0];
                  wr_ok = 1'b1;
                end
              end
              REG_COEF_HI:
              begin
                coef_hi_nxt = rx_val_r;
                wr_ok = 1'b1;
              end
              REG_COEF_LO:
              begin
                coef_lo_nxt = rx_val_r;
                wr_ok = 1'b1;
              end
              default: wr_ok = 1'b0;
            endcase
            if (wr_ok)
            begin
              echo_nxt = 1'b1;
              state_nxt = ST_FETCH;
            end
          end
        end
      end
      ST_FETCH:
      begin
        state_nxt = ST_LOAD;
      end
      ST_LOAD:
      begin
        tx_data_nxt = echo_r ? mem_rdata : out_byte;
        tx_valid_nxt = 1'b1;
        if (!echo_r && (idx_r < POS_VAL_LO))
        begin
          crc_nxt = crc16_step(crc_r, out_byte);
        end
        state_nxt = ST_SEND;
      end
      ST_SEND:
      begin
        if (i_tx_ready)
        begin
          tx_valid_nxt = 1'b0;
          if (idx_r == last_idx)
          begin
            rx_cnt_nxt = POS_ID;
            crc_nxt = CRC_INIT;
            state_nxt = ST_RECV;
          end
          else
          begin
            idx_nxt = idx_r + 3'h1;
            state_nxt = ST_FETCH;
          end
        end
      end
      ST_DROP:
      begin
        if (i_rx_gap)
        begin
          rx_cnt_nxt = POS_ID;
          crc_nxt = CRC_INIT;
          state_nxt = ST_RECV;
        end
      end
      default:
      begin
        state_nxt = ST_DROP;
      end
    endcase
    baud_nxt = baud_of(rate_nxt);
    coef_nxt = {coef_hi_nxt, 8'h00} + {8'h00, coef_lo_nxt};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= ST_RECV;
      rx_cnt_r <= POS_ID;
      crc_r <= CRC_INIT;
      rx_id_r <= 8'h00;
      rx_func_r <= 8'h00;
      rx_addr_r <= 16'h0000;
      rx_val_r <= 16'h0000;
      echo_r <= 1'b0;
      idx_r <= POS_ID;
      rd_word_r <= 16'h0000;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      station_r <= STATION_RST;
      rate_r <= RATE_RST;
      coef_hi_r <= COEF_HI_RST;
      coef_lo_r <= COEF_LO_RST;
      baud_r <= BAUD_9600;
      coef_r <= {COEF_HI_RST, 8'h00} + {8'h00, COEF_LO_RST};
    end
    else
    begin
      state_r <= state_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      crc_r <= crc_nxt;
      rx_id_r <= rx_id_nxt;
      rx_func_r <= rx_func_nxt;
      rx_addr_r <= rx_addr_nxt;
      rx_val_r <= rx_val_nxt;
      echo_r <= echo_nxt;
      idx_r <= idx_nxt;
      rd_word_r <= rd_word_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
      station_r <= station_nxt;
      rate_r <= rate_nxt;
      coef_hi_r <= coef_hi_nxt;
      coef_lo_r <= coef_lo_nxt;
      baud_r <= baud_nxt;
      coef_r <= coef_nxt;
    end
  end

  assign o_tx_valid = tx_valid_r;
  assign o_tx_data = tx_data_r;
  assign o_station_id = station_r;
  assign o_line_rate_code = rate_r;
  assign o_baud_rate = baud_r;
  assign o_coefficient = coef_r;

endmodule : radiation_sensor_modbus_slave

/* File: tb/radiation_sensor_modbus_slave_asserts.sv */
module radiation_sensor_modbus_slave_asserts
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic [7:0] o_station_id,
  input wire logic [2:0] o_line_rate_code,
  input wire logic [16:0] o_baud_rate,
  input wire logic [23:0] o_coefficient
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte not held");
  tx_gap_a: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid [*2])
    else $error("reply spacing wrong");
  rate_max_a: assert property (o_line_rate_code <= 3'h5)
    else $error("rate code out of range");
  baud_mid_a: assert property ($stable(o_line_rate_code) && o_line_rate_code == 3'h2 |-> o_baud_rate == 17'd19200)
    else $error("code 2 not 19200");
  baud_top_a: assert property ($stable(o_line_rate_code) && o_line_rate_code == 3'h5 |-> o_baud_rate == 17'd115200)
    else $error("code 5 not 115200");
  id_range_a: assert property (o_station_id inside {[8'h01:8'hfe]})
    else $error("station id out of range");
  id_echo_a: assert property ($changed(o_station_id) |-> !o_tx_valid ##[1:4] o_tx_valid)
    else $error("id change without echo");
  rate_echo_a: assert property ($changed(o_line_rate_code) |-> !o_tx_valid ##[1:4] o_tx_valid)
    else $error("rate change without echo");
  coef_quiet_a: assert property ($changed(o_coefficient) |-> !o_tx_valid)
    else $error("coefficient moved mid reply");
endmodule : radiation_sensor_modbus_slave_asserts

bind radiation_sensor_modbus_slave radiation_sensor_modbus_slave_asserts chk_u
(
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_tx_ready(i_tx_ready),
  .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data),
  .o_station_id(o_station_id),
  .o_line_rate_code(o_line_rate_code),
  .o_baud_rate(o_baud_rate),
  .o_coefficient(o_coefficient)
);

/* File: tb/modbus_host_model.sv */
module modbus_host_model
(
  input wire logic i_core_clk,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_gap,
  output logic o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sent[$];
  logic [7:0] got[$];
  logic tog = 1'b0;
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_gap = 1'b0;
  end
  // slow mode accepts every other cycle
  assign o_tx_ready = !i_slow || tog;
  always @(negedge i_core_clk)
    tog <= ~tog;
  always @(posedge i_core_clk)
    if (i_tx_valid && o_tx_ready)
      got.push_back(i_tx_data);
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc_of
  // id, function, two fields, crc low first
  task send(input logic [47:0] f, input logic bad);
    logic [15:0] c;
    sent = {};
    got = {};
    for (int i = 5; i >= 0; i--)
      sent.push_back(f[i*8 +: 8]);
    c = crc_of(sent) ^ {15'h0000, bad};
    sent.push_back(c[7:0]);
    sent.push_back(c[15:8]);
    @(negedge i_core_clk) o_rx_gap = 1'b1;
    @(negedge i_core_clk) o_rx_gap = 1'b0;
    foreach (sent[i])
    begin
      o_rx_valid = 1'b1;
      o_rx_data = sent[i];
      @(negedge i_core_clk);
    end
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask : send
endmodule : modbus_host_model

/* File: tb/radiation_sensor_modbus_slave_test.sv */
module radiation_sensor_modbus_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic rx_valid, rx_gap, tx_ready, tx_valid;
  logic [7:0] rx_data, tx_data, station_id;
  logic [15:0] reading = 16'h000a;
  logic [2:0] rate_code;
  logic [16:0] baud;
  logic [23:0] coef;
  logic [16:0] bauds[6] = '{17'd4800, 17'd9600, 17'd19200, 17'd38400, 17'd57600, 17'd115200};
  int err_total = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  radiation_sensor_modbus_slave dut_u
  (
    .i_core_clk(clk),
    .i_rst_n(rst_n),
    .i_rx_valid(rx_valid),
    .i_rx_data(rx_data),
    .i_rx_gap(rx_gap),
    .i_tx_ready(tx_ready),
    .i_reading(reading),
    .o_tx_valid(tx_valid),
    .o_tx_data(tx_data),
    .o_station_id(station_id),
    .o_line_rate_code(rate_code),
    .o_baud_rate(baud),
    .o_coefficient(coef)
  );
  modbus_host_model host_u
  (
    .i_core_clk(clk),
    .i_slow(slow),
    .i_tx_valid(tx_valid),
    .i_tx_data(tx_data),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data),
    .o_rx_gap(rx_gap),
    .o_tx_ready(tx_ready)
  );
  task tally_and_finish();
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t mismatch seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic [47:0] f, input logic bad, input int n);
    host_u.send(f, bad);
    for (int k = 0; k < 120 && host_u.got.size() < n; k++)
      @(negedge clk);
    repeat (4) @(negedge clk);
    chk(host_u.got.size(), n);
  endtask : xfer
  task rd(input logic [7:0] id, input logic [7:0] own, input logic [15:0] v);
    logic [7:0] e[$];
    logic [15:0] c;
    reading = v;
    xfer({id, 8'h03, 32'h00000001}, 1'b0, 7);
    e = {own, 8'h03, 8'h02, v[15:8], v[7:0]};
    c = host_u.crc_of(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    foreach (e[i])
      chk(host_u.got[i], e[i]);
  endtask : rd
  task wr(input logic [7:0] id, input logic [15:0] a, input logic [15:0] v, input int n);
    xfer({id, 8'h06, a, v}, 1'b0, n);
    for (int i = 0; i < n; i++)
      chk(host_u.got[i], host_u.sent[i]);
  endtask : wr
  task t_reset();
    chk({station_id, rate_code, baud}, {8'h01, 3'h1, 17'd9600});
    chk(coef, 24'h000064);
  endtask : t_reset
  task t_read();
    rd(8'h01, 8'h01, 16'h000a);
    chk({host_u.got[5], host_u.got[6]}, 16'h3843);
    slow = 1'b1;
    rd(8'h00, 8'h01, 16'hffff);
    slow = 1'b0;
  endtask : t_read
  task t_addr();
    wr(8'h01, 16'h0100, 16'h0002, 8);
    chk({host_u.got[6], host_u.got[7]}, 16'h09f7);
    chk(station_id, 8'h02);
    xfer({8'h01, 8'h03, 32'h00000001}, 1'b0, 0);
    rd(8'h02, 8'h02, 16'h1234);
    wr(8'h00, 16'h0100, 16'h00ff, 0);
    chk(station_id, 8'h02);
    wr(8'h00, 16'h0100, 16'h0001, 8);
  endtask : t_addr
  task t_rate();
    wr(8'h01, 16'h0101, 16'h0002, 8);
    chk({host_u.got[6], host_u.got[7]}, 16'h5837);
    chk(baud, 17'd19200);
    for (int c = 0; c < 6; c++)
    begin
      wr(8'h00, 16'h0101, 16'(c), 8);
      chk({rate_code, baud}, {3'(c), bauds[c]});
    end
    wr(8'h01, 16'h0101, 16'h0006, 0);
    chk(rate_code, 3'h5);
  endtask : t_rate
  task t_misc();
    xfer({8'h01, 8'h03, 32'h00000001}, 1'b1, 0);
    rd(8'h01, 8'h01, 16'h0bad);
    wr(8'h01, 16'h0108, 16'h0001, 8);
    wr(8'h01, 16'h0109, 16'h0002, 8);
    chk(coef, 24'h000102);
  endtask : t_misc
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_read();
    t_addr();
    t_rate();
    t_misc();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(negedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule : radiation_sensor_modbus_slave_test
